// ---- pcrb_map.svh ----
// register offsets, field positions and reset values of the loop-one bank
`ifndef PCRB_MAP_SVH
`define PCRB_MAP_SVH

// ==========================================
// offsets
`define PCRB_OFS_FIRST 8'h08
`define PCRB_NUM_REGS 7
`define PCRB_OFS_REF_DIV 8'h08
`define PCRB_OFS_FB_LOW 8'h09
`define PCRB_OFS_FILTER_FB_HIGH 8'h0a
`define PCRB_OFS_PUMP 8'h0b
`define PCRB_OFS_SPREAD_REF 8'h0c
`define PCRB_OFS_SPREAD_FB_HIGH 8'h0d
`define PCRB_OFS_SPREAD_FB_LOW 8'h0e

// ==========================================
// reset values
`define PCRB_RST_REF_DIV 8'h19
`define PCRB_RST_FB_LOW 8'h58
`define PCRB_RST_FILTER_FB_HIGH 8'hb2
`define PCRB_RST_PUMP 8'h06
`define PCRB_RST_SPREAD_REF 8'h00
`define PCRB_RST_SPREAD_FB_HIGH 8'h00
`define PCRB_RST_SPREAD_FB_LOW 8'h00
`define PCRB_RST_REF_RATIO 6'h19
`define PCRB_RST_FB_RATIO 11'h258
`define PCRB_UNMAPPED_DATA 8'h00

// ==========================================
// field positions
`define PCRB_BIT_DIV_ONE 7
`define PCRB_BIT_DIV_TWO 6
`define PCRB_BIT_RES_100K 7
`define PCRB_BIT_RES_50K 6
`define PCRB_BIT_RES_25K 5
`define PCRB_BIT_RES_12K5 4
`define PCRB_BIT_RES_1K 3
`define PCRB_BIT_PUMP_32 7
`define PCRB_BIT_PUMP_16 6
`define PCRB_BIT_PUMP_8 5
`define PCRB_BIT_PUMP_4 4
`define PCRB_BIT_PUMP_2 3
`define PCRB_BIT_PUMP_1 2
`define PCRB_BIT_PUMP_DIV24 1
`define PCRB_BIT_PUMP_DIV3 0
`define PCRB_BIT_SPREAD_23 7

`endif

// ---- pcrb_pkg.sv ----
// types shared by the loop-one configuration bank
package pcrb_pkg;

    // ==========================================
    // register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcrb_req_t;

    // ==========================================
    // static configuration to the analogue loop
    typedef struct packed {
        logic ref_div_by_one_select;
        logic ref_div_by_two_select;
        logic [5:0] ref_divide_ratio;
        logic [10:0] feedback_divide_ratio;
        logic filter_res_100k_add;
        logic filter_res_50k_add;
        logic filter_res_25k_add;
        logic filter_res_12k5_add;
        logic filter_res_1k_only;
        logic pump_weight_32;
        logic pump_weight_16;
        logic pump_weight_8;
        logic pump_weight_4;
        logic pump_weight_2;
        logic pump_weight_1;
        logic pump_divide_24;
        logic pump_divide_3;
        logic spread_ref_divide_23;
        logic [6:0] spread_ref_divide;
        logic [15:0] spread_feedback_divide;
    } pcrb_cfg_t;

endpackage

// ---- pcrb_read_mux.sv ----
// read selection over the bank, zero for unmapped offsets
`timescale 1ns/1ps
`include "pcrb_map.svh"
module pcrb_read_mux #(
    parameter int NUM = `PCRB_NUM_REGS
) (
    // bank contents
    input wire logic [NUM-1:0][7:0] regs,
    // address
    input wire logic [7:0] addr,
    // selection
    output logic hit,
    output logic [7:0] data
);

    logic [7:0] idx;

    always_comb begin
        idx = addr - `PCRB_OFS_FIRST;
        hit = (addr >= `PCRB_OFS_FIRST) && (idx < 8'(NUM));
        data = `PCRB_UNMAPPED_DATA;
        if (hit) begin
            data = regs[idx[$clog2(NUM)-1:0]];
        end
    end

endmodule

// ---- pcrb_reg_byte.sv ----
// one read/write byte with a fixed reset value
`timescale 1ns/1ps
module pcrb_reg_byte #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    // stored value
    output logic [7:0] q
);

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= RESET_VAL;
        end else if (wr_en) begin
            q <= wdata;
        end
    end

endmodule

// ---- pcrb_top.sv ----
// loop-one configuration register bank, offsets 08h to 0eh
`timescale 1ns/1ps
`include "pcrb_map.svh"
module pcrb_top #(
    parameter int NUM_REGS = `PCRB_NUM_REGS
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    // register access from the serial control interface
    input wire pcrb_pkg::pcrb_req_t REG_REQ,
    output logic REG_HIT,
    output logic REG_RVALID,
    output logic [7:0] REG_RDATA,
    // configuration to the loop
    output pcrb_pkg::pcrb_cfg_t CFG
);
    import pcrb_pkg::*;

    // ==========================================
    // bank storage
    localparam logic [8*`PCRB_NUM_REGS-1:0] RST_TABLE = {
        `PCRB_RST_SPREAD_FB_LOW,
        `PCRB_RST_SPREAD_FB_HIGH,
        `PCRB_RST_SPREAD_REF,
        `PCRB_RST_PUMP,
        `PCRB_RST_FILTER_FB_HIGH,
        `PCRB_RST_FB_LOW,
        `PCRB_RST_REF_DIV
    };

    logic [NUM_REGS-1:0][7:0] regs;
    logic [NUM_REGS-1:0] wr_sel;
    logic mux_hit;
    logic [7:0] mux_data;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            localparam logic [7:0] OFS = 8'(`PCRB_OFS_FIRST + gi);
            // byte write strobe per offset
            assign wr_sel[gi] = REG_REQ.wr && (REG_REQ.addr == OFS);
            pcrb_reg_byte #(
                .RESET_VAL(RST_TABLE[gi*8 +: 8])
            ) u_byte (
                .clk(SYS_CLK),
                .rst(SYS_RST),
                .wr_en(wr_sel[gi]),
                .wdata(REG_REQ.wdata),
                .q(regs[gi])
            );
        end
    endgenerate

    // ==========================================
    // read path
    pcrb_read_mux #(
        .NUM(NUM_REGS)
    ) u_mux (
        .regs(regs),
        .addr(REG_REQ.addr),
        .hit(mux_hit),
        .data(mux_data)
    );

    assign REG_HIT = mux_hit;

    // read data captured on the read edge, no side effects
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= `PCRB_UNMAPPED_DATA;
        end else if (REG_REQ.rd) begin
            REG_RDATA <= mux_data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_REQ.rd;
        end
    end

    // ==========================================
    // byte views
    localparam int I_REF = int'(`PCRB_OFS_REF_DIV) - int'(`PCRB_OFS_FIRST);
    localparam int I_FBL = int'(`PCRB_OFS_FB_LOW) - int'(`PCRB_OFS_FIRST);
    localparam int I_FLT = int'(`PCRB_OFS_FILTER_FB_HIGH) - int'(`PCRB_OFS_FIRST);
    localparam int I_PMP = int'(`PCRB_OFS_PUMP) - int'(`PCRB_OFS_FIRST);
    localparam int I_SRF = int'(`PCRB_OFS_SPREAD_REF) - int'(`PCRB_OFS_FIRST);
    localparam int I_SFH = int'(`PCRB_OFS_SPREAD_FB_HIGH) - int'(`PCRB_OFS_FIRST);
    localparam int I_SFL = int'(`PCRB_OFS_SPREAD_FB_LOW) - int'(`PCRB_OFS_FIRST);

    logic [7:0] b_ref;
    logic [7:0] b_fbl;
    logic [7:0] b_flt;
    logic [7:0] b_pmp;
    logic [7:0] b_srf;
    logic [7:0] b_sfh;
    logic [7:0] b_sfl;

    assign b_ref = regs[I_REF];
    assign b_fbl = regs[I_FBL];
    assign b_flt = regs[I_FLT];
    assign b_pmp = regs[I_PMP];
    assign b_srf = regs[I_SRF];
    assign b_sfh = regs[I_SFH];
    assign b_sfl = regs[I_SFL];

    // ==========================================
    // configuration fields
    assign CFG.ref_div_by_one_select = b_ref[`PCRB_BIT_DIV_ONE];
    assign CFG.ref_div_by_two_select = b_ref[`PCRB_BIT_DIV_TWO];
    assign CFG.ref_divide_ratio = b_ref[5:0];
    assign CFG.feedback_divide_ratio = {b_flt[2:0], b_fbl};
    assign CFG.filter_res_100k_add = b_flt[`PCRB_BIT_RES_100K];
    assign CFG.filter_res_50k_add = b_flt[`PCRB_BIT_RES_50K];
    assign CFG.filter_res_25k_add = b_flt[`PCRB_BIT_RES_25K];
    assign CFG.filter_res_12k5_add = b_flt[`PCRB_BIT_RES_12K5];
    assign CFG.filter_res_1k_only = b_flt[`PCRB_BIT_RES_1K];
    assign CFG.pump_weight_32 = b_pmp[`PCRB_BIT_PUMP_32];
    assign CFG.pump_weight_16 = b_pmp[`PCRB_BIT_PUMP_16];
    assign CFG.pump_weight_8 = b_pmp[`PCRB_BIT_PUMP_8];
    assign CFG.pump_weight_4 = b_pmp[`PCRB_BIT_PUMP_4];
    assign CFG.pump_weight_2 = b_pmp[`PCRB_BIT_PUMP_2];
    assign CFG.pump_weight_1 = b_pmp[`PCRB_BIT_PUMP_1];
    assign CFG.pump_divide_24 = b_pmp[`PCRB_BIT_PUMP_DIV24];
    assign CFG.pump_divide_3 = b_pmp[`PCRB_BIT_PUMP_DIV3];
    assign CFG.spread_ref_divide_23 = b_srf[`PCRB_BIT_SPREAD_23];
    assign CFG.spread_ref_divide = b_srf[6:0];
    assign CFG.spread_feedback_divide = {b_sfh, b_sfl};

    // ==========================================
    // checks
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);

    sequence reset_release_s;
        $past(SYS_RST) && !SYS_RST;
    endsequence

    sequence wr_ref_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_REF_DIV;
    endsequence

    sequence wr_fbl_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_FB_LOW;
    endsequence

    sequence wr_flt_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_FILTER_FB_HIGH;
    endsequence

    sequence wr_pmp_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_PUMP;
    endsequence

    sequence wr_srf_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_SPREAD_REF;
    endsequence

    sequence wr_sfh_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_SPREAD_FB_HIGH;
    endsequence

    sequence wr_sfl_s;
        REG_REQ.wr && REG_REQ.addr == `PCRB_OFS_SPREAD_FB_LOW;
    endsequence

    sequence no_wr_s;
        !REG_REQ.wr;
    endsequence

    sequence rd_s;
        REG_REQ.rd;
    endsequence

    div_one_sel_a: assert property (
        (reset_release_s |-> !CFG.ref_div_by_one_select) and
        (wr_ref_s |=> CFG.ref_div_by_one_select == $past(REG_REQ.wdata[7])))
        else $error("divide-by-one select wrong");

    div_two_sel_a: assert property (
        (reset_release_s |-> !CFG.ref_div_by_two_select) and
        (wr_ref_s |=> CFG.ref_div_by_two_select == $past(REG_REQ.wdata[6])))
        else $error("divide-by-two select wrong");

    ref_ratio_a: assert property (
        (reset_release_s |-> CFG.ref_divide_ratio == `PCRB_RST_REF_RATIO) and
        (wr_ref_s |=> CFG.ref_divide_ratio == $past(REG_REQ.wdata[5:0])))
        else $error("reference ratio wrong");

    fb_split_a: assert property (
        (wr_fbl_s ##1 wr_flt_s) |=>
        CFG.feedback_divide_ratio == {$past(REG_REQ.wdata[2:0]), $past(REG_REQ.wdata, 2)})
        else $error("feedback ratio byte split wrong");

    fb_reset_a: assert property (
        reset_release_s |-> CFG.feedback_divide_ratio == `PCRB_RST_FB_RATIO)
        else $error("feedback ratio reset not 600");

    filter_res_a: assert property (
        (reset_release_s |-> {CFG.filter_res_100k_add, CFG.filter_res_50k_add,
            CFG.filter_res_25k_add, CFG.filter_res_12k5_add} == 4'hb) and
        (wr_flt_s |=> {CFG.filter_res_100k_add, CFG.filter_res_50k_add,
            CFG.filter_res_25k_add, CFG.filter_res_12k5_add} == $past(REG_REQ.wdata[7:4])))
        else $error("filter resistor selects wrong");

    filter_one_k_a: assert property (
        (reset_release_s |-> !CFG.filter_res_1k_only) and
        (wr_flt_s |=> CFG.filter_res_1k_only == $past(REG_REQ.wdata[3])))
        else $error("1k filter select wrong");

    pump_ctrl_a: assert property (
        (reset_release_s |-> {CFG.pump_weight_32, CFG.pump_weight_16, CFG.pump_weight_8,
            CFG.pump_weight_4, CFG.pump_weight_2, CFG.pump_weight_1,
            CFG.pump_divide_24, CFG.pump_divide_3} == `PCRB_RST_PUMP) and
        (wr_pmp_s |=> {CFG.pump_weight_32, CFG.pump_weight_16, CFG.pump_weight_8,
            CFG.pump_weight_4, CFG.pump_weight_2, CFG.pump_weight_1,
            CFG.pump_divide_24, CFG.pump_divide_3} == $past(REG_REQ.wdata)))
        else $error("charge pump controls wrong");

    spread_ref_a: assert property (
        (reset_release_s |-> {CFG.spread_ref_divide_23, CFG.spread_ref_divide} == 8'h00) and
        (wr_srf_s |=> {CFG.spread_ref_divide_23, CFG.spread_ref_divide} ==
            $past(REG_REQ.wdata)))
        else $error("spread reference divider wrong");

    spread_fb_high_a: assert property (
        (reset_release_s |-> CFG.spread_feedback_divide[15:8] == 8'h00) and
        (wr_sfh_s |=> CFG.spread_feedback_divide[15:8] == $past(REG_REQ.wdata)))
        else $error("spread feedback high byte wrong");

    spread_fb_low_a: assert property (
        (reset_release_s |-> CFG.spread_feedback_divide[7:0] == 8'h00) and
        (wr_sfl_s |=> CFG.spread_feedback_divide[7:0] == $past(REG_REQ.wdata)))
        else $error("spread feedback low byte wrong");

    read_back_a: assert property (
        (REG_REQ.wr && !REG_REQ.rd ##1 REG_REQ.rd && !REG_REQ.wr &&
            REG_REQ.addr == $past(REG_REQ.addr) && REG_HIT) |=>
        REG_RVALID && REG_RDATA == $past(REG_REQ.wdata, 2))
        else $error("read does not return last write");

    read_quiet_a: assert property (
        (REG_REQ.rd && !REG_REQ.wr) |=> $stable(CFG))
        else $error("read changed configuration");

    unmapped_read_a: assert property (
        (REG_REQ.rd && !REG_HIT) |=> REG_RVALID && REG_RDATA == `PCRB_UNMAPPED_DATA)
        else $error("unmapped read not zero");

    hit_decode_a: assert property (
        REG_HIT == ((REG_REQ.addr >= `PCRB_OFS_FIRST) &&
            (REG_REQ.addr <= `PCRB_OFS_SPREAD_FB_LOW)))
        else $error("address decode wrong");

    rvalid_pulse_a: assert property (
        (rd_s |=> REG_RVALID) and (!REG_REQ.rd |=> !REG_RVALID))
        else $error("read valid pulse wrong");

    rdata_hold_a: assert property (
        !REG_REQ.rd |=> $stable(REG_RDATA))
        else $error("read data moved without a read");

    rst_outputs_a: assert property (
        reset_release_s |-> !REG_RVALID && REG_RDATA == `PCRB_UNMAPPED_DATA)
        else $error("read outputs not cleared by reset");

    cfg_hold_a: assert property (
        no_wr_s |=> $stable(CFG))
        else $error("configuration moved without a write");

    unmapped_write_a: assert property (
        (REG_REQ.wr && !REG_HIT) |=> $stable(CFG))
        else $error("unmapped write changed configuration");

    fb_low_alone_a: assert property (
        wr_fbl_s |=> $stable(CFG.feedback_divide_ratio[10:8]))
        else $error("low feedback write moved the high bits");

    fb_high_alone_a: assert property (
        wr_flt_s |=> $stable(CFG.feedback_divide_ratio[7:0]))
        else $error("high feedback write moved the low bits");

    spread_fb_split_a: assert property (
        (wr_sfh_s ##1 wr_sfl_s) |=>
        CFG.spread_feedback_divide == {$past(REG_REQ.wdata, 2), $past(REG_REQ.wdata)})
        else $error("spread feedback byte split wrong");

endmodule

// ---- pcrb_top_tb.sv ----
// self-checking testbench for the loop-one configuration bank
`timescale 1ns/1ps
module pcrb_top_tb;
    import pcrb_pkg::*;

    // ==========================================
    // clock, reset and bench state
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    pcrb_req_t req = '0;
    logic reg_hit;
    logic reg_rvalid;
    logic [7:0] reg_rdata;
    pcrb_cfg_t cfg;
    logic [7:0] mdl [0:6];
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] pats [0:9] = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
        8'h80};

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    pcrb_top i_dut (
        .SYS_CLK(sys_clk),
        .SYS_RST(sys_rst),
        .REG_REQ(req),
        .REG_HIT(reg_hit),
        .REG_RVALID(reg_rvalid),
        .REG_RDATA(reg_rdata),
        .CFG(cfg)
    );

    // ==========================================
    // expectations
    task automatic model_reset();
        mdl[0] = 8'h19;
        mdl[1] = 8'h58;
        mdl[2] = 8'hb2;
        mdl[3] = 8'h06;
        mdl[4] = 8'h00;
        mdl[5] = 8'h00;
        mdl[6] = 8'h00;
    endtask

    function automatic logic mapped(input logic [7:0] a);
        return (a >= 8'h08) && (a <= 8'h0e);
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        return mapped(a) ? mdl[a - 8'h08] : 8'h00;
    endfunction

    function automatic pcrb_cfg_t exp_cfg();
        pcrb_cfg_t c;
        c.ref_div_by_one_select = mdl[0][7];
        c.ref_div_by_two_select = mdl[0][6];
        c.ref_divide_ratio = mdl[0][5:0];
        c.feedback_divide_ratio = {mdl[2][2:0], mdl[1]};
        {c.filter_res_100k_add, c.filter_res_50k_add, c.filter_res_25k_add} = mdl[2][7:5];
        c.filter_res_12k5_add = mdl[2][4];
        c.filter_res_1k_only = mdl[2][3];
        {c.pump_weight_32, c.pump_weight_16, c.pump_weight_8} = mdl[3][7:5];
        {c.pump_weight_4, c.pump_weight_2, c.pump_weight_1} = mdl[3][4:2];
        c.pump_divide_24 = mdl[3][1];
        c.pump_divide_3 = mdl[3][0];
        c.spread_ref_divide_23 = mdl[4][7];
        c.spread_ref_divide = mdl[4][6:0];
        c.spread_feedback_divide = {mdl[5], mdl[6]};
        return c;
    endfunction

    // ==========================================
    // compare and close
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            wrap_up();
        end
    end

    // ==========================================
    // register accesses
    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
        #1;
        if (mapped(a)) begin
            mdl[a - 8'h08] = d;
        end
        check("cfg", 64'(cfg), 64'(exp_cfg()));
    endtask

    task automatic do_read(input logic [7:0] a);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        #1;
        check("hit", 64'(reg_hit), 64'(mapped(a)));
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        check("rvalid", 64'(reg_rvalid), 64'h1);
        check("rdata", 64'(reg_rdata), 64'(exp_rd(a)));
    endtask

    // two writes to neighbouring offsets, then a read, with no idle cycle
    task automatic do_burst(input logic [7:0] a1, input logic [7:0] d1, input logic [7:0] d2);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a1, wdata: d1};
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a1 + 8'h01, wdata: d2};
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a1 + 8'h01, wdata: 8'h00};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        mdl[a1 - 8'h08] = d1;
        mdl[a1 - 8'h07] = d2;
        check("burst rvalid", 64'(reg_rvalid), 64'h1);
        check("burst rdata", 64'(reg_rdata), 64'(d2));
        check("burst cfg", 64'(cfg), 64'(exp_cfg()));
    endtask

    task automatic check_reset_state();
        model_reset();
        check("reset cfg", 64'(cfg), 64'(exp_cfg()));
        check("reset rvalid", 64'(reg_rvalid), 64'h0);
        for (int i = 8; i <= 14; i++) begin
            do_read(8'(i));
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] old;
        void'($urandom(74));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        check_reset_state();
        // walking patterns over every byte
        for (int r = 8; r <= 14; r++) begin
            for (int p = 0; p < 10; p++) begin
                do_write(8'(r), pats[p]);
                do_read(8'(r));
            end
        end
        // ratio boundaries stored as written
        do_write(8'h08, 8'h03);
        check("ref ratio", 64'(cfg.ref_divide_ratio), 64'h3);
        do_write(8'h09, 8'h0c);
        do_write(8'h0a, 8'h00);
        check("fb ratio", 64'(cfg.feedback_divide_ratio), 64'd12);
        do_write(8'h0a, 8'h07);
        do_write(8'h09, 8'hff);
        check("fb ratio", 64'(cfg.feedback_divide_ratio), 64'd2047);
        do_burst(8'h09, 8'h58, 8'h02);
        check("fb ratio", 64'(cfg.feedback_divide_ratio), 64'd600);
        do_burst(8'h0d, 8'ha5, 8'h5a);
        check("spread fb", 64'(cfg.spread_feedback_divide), 64'ha55a);
        // write and read in one cycle, then read data holds
        old = mdl[3];
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b1, addr: 8'h0b, wdata: ~old};
        @(posedge sys_clk);
        req <= '0;
        #1;
        check("rdata old", 64'(reg_rdata), 64'(old));
        mdl[3] = ~old;
        check("cfg", 64'(cfg), 64'(exp_cfg()));
        @(posedge sys_clk);
        #1;
        check("rvalid low", 64'(reg_rvalid), 64'h0);
        check("rdata hold", 64'(reg_rdata), 64'(old));
        // random traffic with unmapped offsets
        for (int k = 0; k < 300; k++) begin
            a = 8'($urandom_range(0, 20));
            if ($urandom_range(0, 9) == 0) begin
                a = 8'hff;
            end
            d = 8'($urandom());
            if ($urandom_range(0, 9) == 9) begin
                do_burst(($urandom_range(0, 1) == 1) ? 8'h0d : 8'h09, d, 8'($urandom()));
            end else if ($urandom_range(0, 1) == 1) begin
                do_write(a, d);
            end else begin
                do_read(a);
            end
        end
        // second reset in mid-run
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        check("reset rdata", 64'(reg_rdata), 64'h0);
        check_reset_state();
        wrap_up();
    end
endmodule
